// *** rtl/ccs_pkg.sv ***
// package: constants and carrier types of the cpu clock switchover control
`default_nettype none
package ccs_pkg;
   localparam int unsigned DIV_W = 3;
   localparam int unsigned CNT_W = 10;
   localparam logic [2:0] DIV_MAX = 3'h4;
   localparam logic [2:0] DIV_RESET = 3'h0;
   // register bit positions
   localparam int unsigned CPU_CTL_DIV_LSB = 0;
   localparam int unsigned CPU_CTL_SEL_BIT = 4;
   localparam int unsigned CPU_CTL_STAT_BIT = 5;
   localparam int unsigned MAIN_MODE_SEL_BIT = 0;
   localparam int unsigned MAIN_MODE_STAT_BIT = 1;
   localparam int unsigned MAIN_MODE_XEN_BIT = 2;
   // source frequencies in hz
   localparam longint unsigned INTERNAL_FAST_OSC_FREQ = 64'd8000000;
   localparam longint unsigned HIGH_SPEED_CLOCK_FREQ = 64'd10000000;
   localparam longint unsigned SUB_CLOCK_FREQ = 64'd32768;
   localparam longint unsigned INTERNAL_SLOW_OSC_FREQ = 64'd240000;
   // divider-change delay base, halved per divide step
   localparam logic [CNT_W-1:0] DIV_CHANGE_BASE = 10'h010;
   localparam logic [CNT_W-1:0] SUB_TO_MAIN_CYCLES = 10'h002;
   // main source switchover, fraction discarded
   localparam logic [CNT_W-1:0] TO_HS_CYCLES = CNT_W'(1 + (2 * INTERNAL_FAST_OSC_FREQ) / HIGH_SPEED_CLOCK_FREQ);
   localparam logic [CNT_W-1:0] TO_INT_CYCLES = CNT_W'(1 + (2 * HIGH_SPEED_CLOCK_FREQ) / INTERNAL_FAST_OSC_FREQ);
   // source masks: {pin, second_h_timer, third_8bit_timer, first_8bit_timer, slow osc, sub, periph}
   localparam logic [6:0] TIMER16_SRC_MASK = 7'h53;
   localparam logic [6:0] WATCHDOG_SRC_MASK = 7'h04;

   typedef struct packed {
      logic cpu_clock_select;
      logic [DIV_W-1:0] main_divide_factor;
   } ccs_cpu_ctl_wr_t;

   typedef struct packed {
      logic main_source_select;
      logic external_source_enable;
   } ccs_main_mode_wr_t;

   typedef struct packed {
      logic cpu_clock_status;
      logic [DIV_W-1:0] main_divide_factor;
      logic main_source_status;
      logic external_source_enable;
   } ccs_status_t;

   typedef enum logic [1:0] {ST_IDLE, ST_CPU_SW, ST_MAIN_SW} ccs_state_t;

   // main-to-sub delay in old cpu clocks, rounded up
   function automatic logic [CNT_W-1:0] ccs_to_sub_cycles(input logic on_hs, input logic [DIV_W-1:0] div);
      longint unsigned num;
      longint unsigned den;
      num = 2 * (on_hs ? HIGH_SPEED_CLOCK_FREQ : INTERNAL_FAST_OSC_FREQ);
      den = SUB_CLOCK_FREQ << div;
      return CNT_W'((num + den - 64'd1) / den);
   endfunction : ccs_to_sub_cycles
endpackage : ccs_pkg
`default_nettype wire

// *** rtl/ccs_switch_delay.sv ***
// switchover delay counter: counts ticks of the old clock
`default_nettype none
module ccs_switch_delay (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic load_i,
   input wire logic [ccs_pkg::CNT_W-1:0] load_val_i,
   input wire logic old_tick_i,
   output logic busy_o,
   output logic done_o
);
   logic [ccs_pkg::CNT_W-1:0] cnt_reg;
   logic [ccs_pkg::CNT_W-1:0] cnt_next;
   logic last_tick;

   assign busy_o = (cnt_reg != '0);
   assign last_tick = busy_o && old_tick_i && (cnt_reg == ccs_pkg::CNT_W'(1));
   assign done_o = last_tick && ce_i;
   assign cnt_next = load_i ? load_val_i : (busy_o && old_tick_i) ? cnt_reg - ccs_pkg::CNT_W'(1) : cnt_reg;

   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
         cnt_reg <= '0;
      else if (ce_i)
         cnt_reg <= cnt_next;
   end
endmodule : ccs_switch_delay
`default_nettype wire

// *** rtl/ccs_clock_control.sv ***
// cpu clock switchover, main source selection and oscillator stop control
`default_nettype none
// Summary of operation
// (R1) software must not change divide factor while moving cpu clock to subsystem
// (R2) one write may change divide factor and move cpu clock back to main
// (R3) switchover delay counts cycles of the cpu clock in use before switching
// (R4) main-to-subsystem delay from frequency ratio is rounded up to whole clocks
// (R5) main source select picks internal fast oscillator or high-speed clock
// (R6) after source select write, old main clock runs on for some cycles
// (R7) main source status shows which main source the cpu really uses
// (R8) main-source switchover takes one plus twice the frequency ratio clocks
// (R9) main-source delay counts old main clocks, fraction discarded
// (R10) software sets external source enable before switching to high-speed clock
// (R11) external source enable changes only once after reset release
// (R12) internal oscillator stop only while on high-speed or subsystem clock
// (R13) main oscillator stop only while on internal oscillator or subsystem clock
// (R14) subsystem oscillator stop only while cpu is off the subsystem clock
// (R15) peripheral source clock options are fixed per peripheral
// (R16) no pin-clocked peripherals while on subsystem with internal oscillator stopped
// (R17) cpu clock select and divide factor choose cpu clock and divide ratio
// (R18) cpu clock status shows main or subsystem clock in use
// (R19) clock selection changes only between ticks, never mid-pulse
module ccs_clock_control (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic fast_osc_tick_i,
   input wire logic hs_clock_tick_i,
   input wire logic sub_clock_tick_i,
   input wire logic cpu_ctl_wr_i,
   input wire ccs_pkg::ccs_cpu_ctl_wr_t cpu_ctl_wdata_i,
   input wire logic main_mode_wr_i,
   input wire ccs_pkg::ccs_main_mode_wr_t main_mode_wdata_i,
   input wire logic internal_osc_stop_i,
   input wire logic main_osc_stop_i,
   input wire logic sub_osc_enable_i,
   output logic main_tick_o,
   output logic cpu_tick_o,
   output logic busy_o,
   output ccs_pkg::ccs_status_t status_o,
   output logic internal_osc_stop_o,
   output logic main_osc_stop_o,
   output logic sub_osc_enable_o,
   output logic [6:0] timer16_src_mask_o,
   output logic [6:0] watchdog_src_mask_o
);
   ccs_pkg::ccs_state_t state_reg;
   ccs_pkg::ccs_state_t state_next;
   logic cpu_sel_reg;
   logic [ccs_pkg::DIV_W-1:0] div_reg;
   logic tgt_sel_reg;
   logic [ccs_pkg::DIV_W-1:0] tgt_div_reg;
   logic main_src_reg;
   logic xen_reg;
   logic xen_locked_reg;
   logic [3:0] div_cnt_reg;
   logic [3:0] div_cnt_next;
   logic [ccs_pkg::DIV_W-1:0] wr_div;
   logic [ccs_pkg::DIV_W-1:0] div_eff;
   logic [3:0] div_top;
   logic div_wrap;
   logic main_tick;
   logic cpu_tick;
   logic cpu_ctl_change;
   logic main_mode_change;
   logic start_cpu;
   logic start_main;
   logic [ccs_pkg::CNT_W-1:0] cpu_delay;
   logic [ccs_pkg::CNT_W-1:0] load_val;
   logic dly_tick;
   logic dly_busy;
   logic dly_done;
   logic xen_accept;

   // main clock chosen by the applied source status
   assign main_tick = main_src_reg ? hs_clock_tick_i : fast_osc_tick_i; // [R5] [R7]
   assign div_eff = (div_reg > ccs_pkg::DIV_MAX) ? ccs_pkg::DIV_MAX : div_reg;
   assign div_top = 4'((5'h01 << div_eff) - 5'h01); // [R17]
   assign div_wrap = main_tick && (div_cnt_reg == div_top);
   assign cpu_tick = cpu_sel_reg ? sub_clock_tick_i : div_wrap; // [R17] [R18]
   assign div_cnt_next = (!main_tick || cpu_sel_reg) ? div_cnt_reg : div_wrap ? 4'h0 : div_cnt_reg + 4'h1;

   // request decode, switchovers accepted only while idle; external source enable accepted in any state
   assign wr_div = (cpu_ctl_wdata_i.main_divide_factor > ccs_pkg::DIV_MAX) ? ccs_pkg::DIV_MAX
                   : cpu_ctl_wdata_i.main_divide_factor;
   assign cpu_ctl_change = cpu_ctl_wr_i
                           && ((cpu_ctl_wdata_i.cpu_clock_select != cpu_sel_reg) || (wr_div != div_reg));
   assign main_mode_change = main_mode_wr_i && (main_mode_wdata_i.main_source_select != main_src_reg);
   assign start_cpu = (state_reg == ccs_pkg::ST_IDLE) && cpu_ctl_change;
   assign start_main = (state_reg == ccs_pkg::ST_IDLE) && !cpu_ctl_change && main_mode_change; // [R6]
   assign xen_accept = main_mode_wr_i && !xen_locked_reg // [R11]
                       && (main_mode_wdata_i.external_source_enable != xen_reg);

   // delay in old cpu clocks for the requested change
   assign cpu_delay = cpu_sel_reg ? ccs_pkg::SUB_TO_MAIN_CYCLES // [R2] [R3]
                      : cpu_ctl_wdata_i.cpu_clock_select ? ccs_pkg::ccs_to_sub_cycles(main_src_reg, div_eff) // [R4]
                      : (ccs_pkg::DIV_CHANGE_BASE >> div_eff); // [R3]
   assign load_val = start_cpu ? cpu_delay
                     : main_src_reg ? ccs_pkg::TO_INT_CYCLES : ccs_pkg::TO_HS_CYCLES; // [R8] [R9]
   assign dly_tick = (state_reg == ccs_pkg::ST_MAIN_SW) ? main_tick : cpu_tick; // [R3] [R9]

   ccs_switch_delay u_delay (
      .core_clk_i(core_clk_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .load_i(start_cpu || start_main),
      .load_val_i(load_val),
      .old_tick_i(dly_tick),
      .busy_o(dly_busy),
      .done_o(dly_done)
   );

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ccs_pkg::ST_IDLE:
         begin
            if (start_cpu)
               state_next = ccs_pkg::ST_CPU_SW;
            else if (start_main)
               state_next = ccs_pkg::ST_MAIN_SW;
         end
         ccs_pkg::ST_CPU_SW,
         ccs_pkg::ST_MAIN_SW:
         begin
            if (dly_done)
               state_next = ccs_pkg::ST_IDLE;
         end
         default:
            state_next = ccs_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
         state_reg <= ccs_pkg::ST_IDLE;
      else if (ce_i)
         state_reg <= state_next;
   end

   // applied cpu clock and divider; switch right after the last old tick
   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
      begin
         cpu_sel_reg <= 1'b0;
         div_reg <= ccs_pkg::DIV_RESET;
         tgt_sel_reg <= 1'b0;
         tgt_div_reg <= ccs_pkg::DIV_RESET;
      end
      else if (ce_i)
      begin
         if (start_cpu)
         begin
            tgt_sel_reg <= cpu_ctl_wdata_i.cpu_clock_select; // [R2]
            tgt_div_reg <= wr_div; // [R2]
         end
         if (dly_done && (state_reg == ccs_pkg::ST_CPU_SW))
         begin
            cpu_sel_reg <= tgt_sel_reg; // [R19]
            div_reg <= tgt_div_reg; // [R19]
         end
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
         div_cnt_reg <= 4'h0;
      else if (ce_i)
         div_cnt_reg <= (dly_done && (state_reg == ccs_pkg::ST_CPU_SW)) ? 4'h0 : div_cnt_next; // [R19]
   end

   // main source status and once-only external source enable
   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
      begin
         main_src_reg <= 1'b0;
         xen_reg <= 1'b0;
         xen_locked_reg <= 1'b0;
      end
      else if (ce_i)
      begin
         if (dly_done && (state_reg == ccs_pkg::ST_MAIN_SW))
            main_src_reg <= !main_src_reg; // [R6] [R7] [R19]
         if (xen_accept)
         begin
            xen_reg <= main_mode_wdata_i.external_source_enable; // [R11]
            xen_locked_reg <= 1'b1; // [R11]
         end
      end
   end

   // oscillator controls and registered outputs
   always_ff @(posedge core_clk_i)
   begin
      if (!resetn_i)
      begin
         internal_osc_stop_o <= 1'b0;
         main_osc_stop_o <= 1'b1;
         sub_osc_enable_o <= 1'b0;
         timer16_src_mask_o <= '0;
         watchdog_src_mask_o <= '0;
      end
      else if (ce_i)
      begin
         internal_osc_stop_o <= internal_osc_stop_i; // [R12]
         main_osc_stop_o <= main_osc_stop_i; // [R13]
         sub_osc_enable_o <= sub_osc_enable_i; // [R14]
         timer16_src_mask_o <= ccs_pkg::TIMER16_SRC_MASK; // [R15]
         watchdog_src_mask_o <= ccs_pkg::WATCHDOG_SRC_MASK; // [R15]
      end
   end

   assign main_tick_o = main_tick && ce_i;
   assign cpu_tick_o = cpu_tick && ce_i;
   assign busy_o = (state_reg != ccs_pkg::ST_IDLE) || dly_busy;
   assign status_o.cpu_clock_status = cpu_sel_reg; // [R18]
   assign status_o.main_divide_factor = div_reg;
   assign status_o.main_source_status = main_src_reg; // [R7]
   assign status_o.external_source_enable = xen_reg;
endmodule : ccs_clock_control
`default_nettype wire

// *** verification/ccs_clock_control_properties.sv ***
// checker: port properties of the clock switchover control
`default_nettype none
module ccs_chk (
   input wire logic core_clk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic fast_osc_tick_i,
   input wire logic hs_clock_tick_i,
   input wire logic sub_clock_tick_i,
   input wire logic internal_osc_stop_i,
   input wire logic main_osc_stop_i,
   input wire logic sub_osc_enable_i,
   input wire logic main_tick_o,
   input wire logic cpu_tick_o,
   input wire logic busy_o,
   input wire ccs_pkg::ccs_status_t status_o,
   input wire logic internal_osc_stop_o,
   input wire logic main_osc_stop_o,
   input wire logic sub_osc_enable_o,
   input wire logic [6:0] timer16_src_mask_o,
   input wire logic [6:0] watchdog_src_mask_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!resetn_i);
   wire logic main_src = status_o.main_source_status;
   wire logic on_sub = status_o.cpu_clock_status;
   wire logic [2:0] dv = status_o.main_divide_factor;
   wire logic xen = status_o.external_source_enable;
   property p_main_tick; main_tick_o == ((main_src ? hs_clock_tick_i : fast_osc_tick_i) & ce_i); endproperty
   a_main_tick: assert property (p_main_tick) else $error("main tick wrong");
   property p_cpu_sub; on_sub |-> cpu_tick_o == (sub_clock_tick_i & ce_i); endproperty
   a_cpu_sub: assert property (p_cpu_sub) else $error("cpu tick wrong");
   property p_masks; $past(resetn_i) && $past(ce_i) |-> {timer16_src_mask_o, watchdog_src_mask_o} == 14'h2984;
   endproperty
   a_masks: assert property (p_masks) else $error("source masks wrong");
   property p_stop; $past(resetn_i) && $past(ce_i) |-> {internal_osc_stop_o, main_osc_stop_o, sub_osc_enable_o}
      == {$past(internal_osc_stop_i), $past(main_osc_stop_i), $past(sub_osc_enable_i)}; endproperty
   a_stop: assert property (p_stop) else $error("stop copies wrong");
   property p_xen; $past(resetn_i) && $past(xen) |-> xen; endproperty
   a_xen: assert property (p_xen) else $error("source enable cleared");
   property p_src_sw; $past(resetn_i) && $changed(main_src) |-> $past(busy_o) && $past(main_tick_o); endproperty
   a_src_sw: assert property (p_src_sw) else $error("source switch off tick");
   property p_sel_sw; $past(resetn_i) && $changed(on_sub) |-> $past(busy_o) && $past(cpu_tick_o); endproperty
   a_sel_sw: assert property (p_sel_sw) else $error("cpu switch off tick");
   property p_div_sw; $past(resetn_i) && $changed(dv) |-> $past(busy_o) && $past(cpu_tick_o); endproperty
   a_div_sw: assert property (p_div_sw) else $error("divide switch off tick");
   c_to_hs: cover property ($rose(main_src));
   c_to_sub: cover property ($rose(on_sub));
   c_back: cover property ($fell(on_sub));
endmodule : ccs_chk
bind ccs_clock_control ccs_chk chk_u (.*);
`default_nettype wire

// *** verification/tb_ccs_clock_control.sv ***
// testbench: self-checking run of the clock switchover control
`default_nettype none
module tb_ccs_clock_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk_i = 1'b0, resetn_i = 1'b0, ce_i = 1'b1, cpu_ctl_wr_i = 1'b0, main_mode_wr_i = 1'b0;
   logic fast_osc_tick_i = 1'b0, hs_clock_tick_i = 1'b0, sub_clock_tick_i = 1'b0;
   logic internal_osc_stop_i = 1'b0, main_osc_stop_i = 1'b0, sub_osc_enable_i = 1'b1;
   ccs_pkg::ccs_cpu_ctl_wr_t cpu_ctl_wdata_i = '0;
   ccs_pkg::ccs_main_mode_wr_t main_mode_wdata_i = '0;
   logic main_tick_o, cpu_tick_o, busy_o, internal_osc_stop_o, main_osc_stop_o, sub_osc_enable_o;
   ccs_pkg::ccs_status_t status_o;
   logic [6:0] timer16_src_mask_o, watchdog_src_mask_o;
   int fails = 0;
   int n_tests = 0;
   int n, fi;
   logic [2:0] cur;
   ccs_clock_control dut_u (.*);
   always #5 core_clk_i = ~core_clk_i;
   // random ticks; oscillator stops only where software may
   // no pin-clocked peripheral is ever started, so none runs with the fast oscillator stopped
   always @(posedge core_clk_i)
   begin
      ce_i <= !resetn_i || ($urandom % 8 != 0);
      fast_osc_tick_i <= 1'($urandom % 2);
      hs_clock_tick_i <= ($urandom % 3 == 0);
      sub_clock_tick_i <= ($urandom % 4 == 0);
      internal_osc_stop_i <= !busy_o && (status_o[1] || status_o[5]) && 1'($urandom);
      main_osc_stop_i <= !busy_o && (!status_o[1] || status_o[5]) && 1'($urandom);
      sub_osc_enable_i <= busy_o || status_o[5] || 1'($urandom);
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_tests++;
      if (s !== e)
      begin
         $display("[ERR] %s expected %0h seen %0h", nm, e, s);
         fails++;
      end
   endtask : chk
   task automatic wr(input logic is_cpu, input logic [3:0] d);
      @(posedge core_clk_i);
      cpu_ctl_wr_i <= is_cpu;
      main_mode_wr_i <= !is_cpu;
      cpu_ctl_wdata_i <= d;
      main_mode_wdata_i <= d[1:0];
      do @(posedge core_clk_i); while (!ce_i);
      cpu_ctl_wr_i <= 1'b0;
      main_mode_wr_i <= 1'b0;
   endtask : wr
   // counts old-clock ticks until the status moves
   task automatic sw(input logic is_cpu, input logic [3:0] d, input int e, input string nm);
      ccs_pkg::ccs_status_t s0;
      s0 = status_o;
      n = 0;
      wr(is_cpu, d);
      for (int i = 0; i < 9000 && status_o === s0; i++)
      begin
         @(negedge core_clk_i);
         if (status_o === s0 && (is_cpu ? cpu_tick_o : main_tick_o))
            n++;
      end
      chk(nm, e, n);
      $display("test %s done after %0d ticks", nm, n);
   endtask : sw
   function automatic int src_sw(input logic to_hs);
      longint unsigned a, b;
      a = to_hs ? ccs_pkg::INTERNAL_FAST_OSC_FREQ : ccs_pkg::HIGH_SPEED_CLOCK_FREQ;
      b = to_hs ? ccs_pkg::HIGH_SPEED_CLOCK_FREQ : ccs_pkg::INTERNAL_FAST_OSC_FREQ;
      return int'(1 + 2 * a / b);
   endfunction : src_sw
   function automatic int to_sub(input logic [2:0] f);
      longint unsigned den;
      den = ccs_pkg::SUB_CLOCK_FREQ << f;
      return int'((2 * ccs_pkg::INTERNAL_FAST_OSC_FREQ + den - 1) / den);
   endfunction : to_sub
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : close_out
   initial
   begin
      #400000;
      fails++;
      close_out();
   end
   initial
   begin
      void'($urandom(84769));
      repeat (4) @(posedge core_clk_i);
      @(negedge core_clk_i);
      chk("reset status", 32'h0, status_o);
      chk("reset osc stop", 32'h1, main_osc_stop_o);
      @(posedge core_clk_i);
      resetn_i <= 1'b1;
      repeat (20) @(negedge core_clk_i);
      chk("masks", 32'h2984, {timer16_src_mask_o, watchdog_src_mask_o});
      wr(1'b0, 4'h1);
      @(negedge core_clk_i);
      chk("enable only", 32'h1, {busy_o, status_o});
      sw(1'b0, 4'h3, src_sw(1'b1), "to high speed");
      chk("on high speed", 32'h3, status_o);
      sw(1'b0, 4'h0, src_sw(1'b0), "to internal");
      chk("enable kept", 32'h1, status_o);
      cur = 3'h0;
      repeat (5)
      begin
         fi = (cur + 1 + $urandom % 4) % 5;
         sw(1'b1, {1'b0, 3'(fi)}, 16 >> cur, "divide change");
         cur = 3'(fi);
         chk("divide factor", {29'h0, cur}, status_o.main_divide_factor);
      end
      sw(1'b1, {1'b1, cur}, to_sub(cur), "to subsystem");
      chk("on subsystem", 32'h1, status_o.cpu_clock_status);
      fi = (cur + 2) % 5;
      sw(1'b1, {1'b0, 3'(fi)}, 2, "back to main");
      chk("factor on return", fi, status_o.main_divide_factor);
      wr(1'b1, {1'b0, 3'(fi)});
      repeat (3) @(negedge core_clk_i);
      chk("unchanged write", 32'h0, busy_o);
      close_out();
   end
endmodule : tb_ccs_clock_control
`default_nettype wire
